// >>> src/dual_port_block_ram.sv
// Purpose: 36 Kb two-port synchronous block memory, splittable into two 18 Kb halves
// Assumes: All ports and APB synchronous to pclk; user logic avoids write collisions
// Notes: Ports 0/1 are A/B of the whole memory or of the low half; ports 2/3 the high half
//
// Contract
// - Storage works as one 36 Kb memory or two separate 18 Kb memories.
// - Whole memory two-port widths per port: 4K x 9, 2K x 18, 1K x 36.
// - With one write and one read port, whole memory also allows 512 x 72.
// - Half memory two-port widths per port: 2K x 9 or 1K x 18.
// - With one write and one read port, half memory also allows 512 x 36.
// - Simple mode fixes write port at 512 x 72/64 or 512 x 36.
// - Ports independent, share only storage; read and write widths chosen apart.
// - Reads and writes complete on one clock edge.
// - Port inputs captured on the port clock, but with async override the output resets act at once; user keeps them synchronous.
// - Output does plain read without write, read-during-write with write.
// - During write output shows new data, old data, or stays unchanged.
// - Output holds until the same port does another operation.
// - Latch stage with optional output register; register mode by default.
// - Wide ports have a write enable per byte plus one for parity.
// - One 64-bit ECC unit with separate encode, decode and error injection.
// - Latch and register stages each reset, sync or async, to init value.
// - Outputs cascade from lower to upper block with optional pipeline register.
// - Contents loadable or clearable before user operation starts.
// - Each port has own enable, write enable, address, data in and out.
`timescale 1ns/1ps
`include "bram_defines.svh"
module dual_port_block_ram (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] port_en,
   input wire logic [3:0][8:0] port_we,
   input wire logic [3:0][11:0] port_addr,
   input wire logic [3:0][63:0] port_din,
   input wire logic [3:0][7:0] port_dinp,
   input wire logic [3:0] port_rst_latch,
   input wire logic [3:0] port_rst_reg,
   output logic [3:0][63:0] port_dout,
   output logic [3:0][7:0] port_doutp,
   input wire logic [1:0][71:0] cas_in,
   input wire logic [1:0] cas_sel,
   output logic [1:0][71:0] cas_out,
   output logic ecc_sbit,
   output logic ecc_dbit
);
   bram_pkg::state_s q;
   bram_pkg::state_s d;
   logic [3:0][71:0] final_word;

   bram_ecc_if ecc ();

   bram_ecc64 bram_ecc64_inst (
      .e(ecc)
   );

   function automatic logic [8:0] row_of(input logic [11:0] a, input logic split);
      return split ? a[10:2] : a[11:3];
   endfunction : row_of

   function automatic logic [2:0] lane_of(input logic [11:0] a, input logic split,
                                          input logic half);
      return split ? {half, a[1:0]} : a[2:0];
   endfunction : lane_of

   function automatic logic [2:0] align_lane(input logic [2:0] l, input logic [1:0] w);
      case (w)
         bram_pkg::W9: return l;
         bram_pkg::W18: return {l[2:1], 1'b0};
         bram_pkg::W36: return {l[2], 2'b00};
         default: return 3'h0;
      endcase
   endfunction : align_lane

   // Clamp requested width to what the current mode allows
   function automatic logic [1:0] fit_w(input logic [1:0] w, input logic split,
                                        input logic simple_dual_port_use);
      logic [1:0] lim;
      lim = split ? (simple_dual_port_use ? bram_pkg::W36 : bram_pkg::W18)
                  : (simple_dual_port_use ? bram_pkg::W72 : bram_pkg::W36);
      return (w > lim) ? lim : w;
   endfunction : fit_w

   function automatic logic [71:0] pack(input logic [63:0] dat, input logic [7:0] par);
      logic [71:0] r;
      r = '0;
      for (int k = 0; k < `LANES; k++)
         r[9*k +: 9] = {par[k], dat[8*k +: 8]};
      return r;
   endfunction : pack

   function automatic logic [63:0] row_data(input logic [71:0] r);
      logic [63:0] v;
      v = '0;
      for (int k = 0; k < `LANES; k++)
         v[8*k +: 8] = r[9*k +: 8];
      return v;
   endfunction : row_data

   function automatic logic [7:0] row_par(input logic [71:0] r);
      logic [7:0] v;
      v = '0;
      for (int k = 0; k < `LANES; k++)
         v[k] = r[9*k + 8];
      return v;
   endfunction : row_par

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= `OFF_STATUS;
   endfunction : mapped

   // Init pattern replicated over all lanes, A ports and B ports apart
   function automatic logic [71:0] srv(input logic [31:0] s, input logic port_b);
      return {8{s[`SRVAL_B_LSB*port_b +: 9]}};
   endfunction : srv

   assign ecc.enc_data = port_din[0];
   assign ecc.dec_data = row_data(q.mem[row_of(port_addr[1], 1'b0)]);
   assign ecc.dec_check = row_par(q.mem[row_of(port_addr[1], 1'b0)]);

   always_comb
   begin
      logic [71:0] old_row;
      logic [71:0] new_row;
      logic [71:0] wdat;
      logic [71:0] src;
      logic [71:0] rdat;
      logic [8:0] row;
      logic [2:0] lane;
      logic [2:0] wl;
      logic [2:0] rl;
      logic [1:0] ww;
      logic [1:0] rw;
      logic [7:0] pc;
      logic split;
      logic simple_dual_port_use;
      logic go;
      logic wr;
      logic upd;
      logic is_b;
      logic dec_mode;
      int k;
      old_row = '0;
      new_row = '0;
      wdat = '0;
      src = '0;
      rdat = '0;
      row = '0;
      lane = '0;
      wl = '0;
      rl = '0;
      ww = '0;
      rw = '0;
      pc = '0;
      go = 1'b0;
      wr = 1'b0;
      upd = 1'b0;
      is_b = 1'b0;
      k = 0;
      d = q;
      split = q.ctrl[`CTRL_SPLIT];
      simple_dual_port_use = q.ctrl[`CTRL_SDP];
      dec_mode = simple_dual_port_use && !split && q.ctrl[`CTRL_DEC];
      // APB read data captured in the setup cycle
      if (psel && !penable && !pwrite)
      begin
         case (paddr)
            `OFF_CTRL: d.prdata = {23'h0, q.ctrl};
            `OFF_PORTCFG: d.prdata = q.portcfg;
            `OFF_SRVAL: d.prdata = q.srval;
            `OFF_INIT_ROW: d.prdata = {23'h0, q.init_row};
            `OFF_INIT_D0: d.prdata = q.init_data[31:0];
            `OFF_INIT_D1: d.prdata = q.init_data[63:32];
            `OFF_INIT_D2: d.prdata = {24'h0, q.init_data[71:64]};
            `OFF_STATUS: d.prdata = {29'h0, q.dbit_seen, q.sbit_seen,
                                     q.st == bram_pkg::ST_CLEAR};
            default: d.prdata = 32'h0000_0000;
         endcase
      end
      // APB write in the access cycle
      if (psel && penable && pwrite && mapped(paddr))
      begin
         case (paddr)
            `OFF_CTRL: d.ctrl = pwdata[`CTRL_W-1:0];
            `OFF_PORTCFG: d.portcfg = pwdata;
            `OFF_SRVAL: d.srval = pwdata;
            `OFF_INIT_ROW: d.init_row = pwdata[8:0];
            `OFF_INIT_D0: d.init_data[31:0] = pwdata;
            `OFF_INIT_D1: d.init_data[63:32] = pwdata;
            `OFF_INIT_D2: d.init_data[71:64] = pwdata[7:0];
            `OFF_INIT_CMD:
            begin
               if (!q.ctrl[`CTRL_RUN] && q.st == bram_pkg::ST_IDLE)
               begin
                  if (pwdata[`CMD_LOAD])
                     d.mem[q.init_row] = q.init_data;
                  if (pwdata[`CMD_CLEAR])
                  begin
                     d.st = bram_pkg::ST_CLEAR;
                     d.clr_row = 9'h000;
                  end
               end
            end
            `OFF_STATUS:
            begin
               if (pwdata[`ST_SBIT])
                  d.sbit_seen = 1'b0;
               if (pwdata[`ST_DBIT])
                  d.dbit_seen = 1'b0;
            end
            default: d.prdata = q.prdata;
         endcase
      end
      // Clear sweeps one row per cycle
      case (q.st)
         bram_pkg::ST_IDLE: d.st = d.st;
         bram_pkg::ST_CLEAR:
         begin
            d.mem[q.clr_row] = '0;
            d.clr_row = q.clr_row + 9'h001;
            if (q.clr_row == `LAST_ROW)
               d.st = bram_pkg::ST_IDLE;
         end
         default: d.st = bram_pkg::ST_IDLE;
      endcase
      // User ports, sampled on pclk, each with its own controls
      for (int p = 0; p < 4; p++)
      begin
         pc = q.portcfg[8*p +: 8];
         is_b = (p % 2) == 1;
         go = q.ctrl[`CTRL_RUN] && q.st == bram_pkg::ST_IDLE && port_en[p]
              && (split || p < 2);
         if (go)
         begin
            row = row_of(port_addr[p], split);
            lane = lane_of(port_addr[p], split, p >= 2);
            ww = fit_w(pc[`PC_WRW +: 2], split, simple_dual_port_use);
            rw = fit_w(pc[`PC_RDW +: 2], split, simple_dual_port_use);
            if (simple_dual_port_use && !is_b)
               ww = split ? bram_pkg::W36 : bram_pkg::W72;
            wl = align_lane(lane, ww);
            rl = align_lane(lane, rw);
            wr = (|port_we[p][7:0]) && !(simple_dual_port_use && is_b);
            old_row = d.mem[row];
            wdat = pack(port_din[p], port_dinp[p]);
            if (simple_dual_port_use && !split && !is_b && q.ctrl[`CTRL_ENC])
            begin
               wdat = pack(port_din[p], ecc.enc_check);
               wdat[0] = wdat[0] ^ (q.ctrl[`CTRL_INJ_S] | q.ctrl[`CTRL_INJ_D]);
               wdat[1] = wdat[1] ^ q.ctrl[`CTRL_INJ_D];
            end
            new_row = old_row;
            if (wr)
            begin
               for (int j = 0; j < `LANES; j++)
               begin
                  k = j - int'(wl);
                  if (k >= 0 && k < (1 << ww) && port_we[p][k])
                  begin
                     new_row[9*j +: 8] = wdat[9*k +: 8];
                     if (ww == bram_pkg::W9 || port_we[p][8])
                        new_row[9*j + 8] = wdat[9*k + 8];
                  end
               end
               d.mem[row] = new_row;
            end
            upd = !(simple_dual_port_use && !is_b);
            src = old_row;
            if (wr)
            begin
               case (bram_pkg::wmode_e'(pc[`PC_WMODE +: 2]))
                  bram_pkg::WRITE_FIRST: src = new_row;
                  bram_pkg::READ_FIRST: src = old_row;
                  bram_pkg::NO_CHANGE: upd = 1'b0;
                  default: src = new_row;
               endcase
            end
            rdat = '0;
            for (int j = 0; j < `LANES; j++)
               if (j < (1 << rw))
                  rdat[9*j +: 9] = src[9*(int'(rl) + j) +: 9];
            if (p == 1 && dec_mode && rw == bram_pkg::W72)
            begin
               rdat = pack(ecc.dec_fixed, ecc.dec_check);
               d.sbit = ecc.sbit;
               d.dbit = ecc.dbit;
               d.sbit_seen = d.sbit_seen | ecc.sbit;
               d.dbit_seen = d.dbit_seen | ecc.dbit;
            end
            if (port_rst_latch[p])
               d.latch[p] = srv(q.srval, is_b);
            else if (upd)
               d.latch[p] = rdat;
            if (port_rst_reg[p])
               d.oreg[p] = srv(q.srval, is_b);
            else
               d.oreg[p] = q.latch[p];
         end
      end
      d.cas_q = cas_in;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         q.ctrl <= `CTRL_RST;
         q.portcfg <= `PORTCFG_RST;
         q.srval <= `SRVAL_RST;
         q.st <= bram_pkg::ST_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

   // Output stage selection, async reset override and cascade
   always_comb
   begin
      logic [7:0] pc;
      pc = '0;
      for (int p = 0; p < 4; p++)
      begin
         pc = q.portcfg[8*p +: 8];
         final_word[p] = pc[`PC_REGEN] ? q.oreg[p] : q.latch[p];
         if (pc[`PC_ARST] && (port_rst_latch[p] || port_rst_reg[p]))
            final_word[p] = srv(q.srval, (p % 2) == 1);
         if (p < 2 && q.ctrl[`CTRL_CAS_EN] && cas_sel[p])
            final_word[p] = q.ctrl[`CTRL_CAS_PIPE] ? q.cas_q[p] : cas_in[p];
         port_dout[p] = row_data(final_word[p]);
         port_doutp[p] = row_par(final_word[p]);
      end
   end

   assign cas_out = final_word[1:0];
   assign prdata = q.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign ecc_sbit = q.sbit;
   assign ecc_dbit = q.dbit;
endmodule : dual_port_block_ram

// >>> src/bram_defines.svh
// Purpose: Offsets, field positions, reset values and sizes for the block memory
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef BRAM_DEFINES_SVH
`define BRAM_DEFINES_SVH
// Register offsets
`define OFF_CTRL 8'h00
`define OFF_PORTCFG 8'h04
`define OFF_SRVAL 8'h08
`define OFF_INIT_ROW 8'h0c
`define OFF_INIT_D0 8'h10
`define OFF_INIT_D1 8'h14
`define OFF_INIT_D2 8'h18
`define OFF_INIT_CMD 8'h1c
`define OFF_STATUS 8'h20
// Control bits
`define CTRL_SPLIT 0
`define CTRL_SDP 1
`define CTRL_ENC 2
`define CTRL_DEC 3
`define CTRL_INJ_S 4
`define CTRL_INJ_D 5
`define CTRL_RUN 6
`define CTRL_CAS_EN 7
`define CTRL_CAS_PIPE 8
`define CTRL_W 9
`define CTRL_RST 9'h000
// Per-port config byte
`define PC_RDW 0
`define PC_WRW 2
`define PC_WMODE 4
`define PC_REGEN 6
`define PC_ARST 7
`define PORTCFG_RST 32'h4040_4040
`define SRVAL_RST 32'h0000_0000
`define SRVAL_B_LSB 16
// Command and status bits
`define CMD_LOAD 0
`define CMD_CLEAR 1
`define ST_BUSY 0
`define ST_SBIT 1
`define ST_DBIT 2
// Array geometry
`define ROWS 512
`define LAST_ROW 9'h1ff
`define LANES 8
`define WORD_W 72
`endif

// >>> src/bram_pkg.sv
// Purpose: Types for the block memory
// Assumes: Constants come from the defines header
// Notes: Row words hold eight 9-bit lanes, lane i at bits 9i+8:9i
`include "bram_defines.svh"
package bram_pkg;
   typedef enum logic [1:0] {W9 = 2'h0, W18 = 2'h1, W36 = 2'h2, W72 = 2'h3} width_e;
   typedef enum logic [1:0] {WRITE_FIRST = 2'h0, READ_FIRST = 2'h1, NO_CHANGE = 2'h2} wmode_e;
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_CLEAR = 2'h1} init_st_e;
   typedef struct packed {
      logic [`ROWS-1:0][`WORD_W-1:0] mem;
      logic [`CTRL_W-1:0] ctrl;
      logic [31:0] portcfg;
      logic [31:0] srval;
      logic [8:0] init_row;
      logic [`WORD_W-1:0] init_data;
      init_st_e st;
      logic [8:0] clr_row;
      logic [3:0][`WORD_W-1:0] latch;
      logic [3:0][`WORD_W-1:0] oreg;
      logic [1:0][`WORD_W-1:0] cas_q;
      logic sbit;
      logic dbit;
      logic sbit_seen;
      logic dbit_seen;
      logic [31:0] prdata;
   } state_s;
endpackage : bram_pkg

// >>> src/bram_ecc_if.sv
// Purpose: Carries encode and decode signals to the ECC unit
// Assumes: Purely combinational exchange
// Notes: Check bits are seven Hamming bits plus overall parity
`timescale 1ns/1ps
interface bram_ecc_if;
   logic [63:0] enc_data;
   logic [7:0] enc_check;
   logic [63:0] dec_data;
   logic [7:0] dec_check;
   logic [63:0] dec_fixed;
   logic sbit;
   logic dbit;
   modport user (output enc_data, output dec_data, output dec_check,
                 input enc_check, input dec_fixed, input sbit, input dbit);
   modport unit (input enc_data, input dec_data, input dec_check,
                 output enc_check, output dec_fixed, output sbit, output dbit);
endinterface : bram_ecc_if

// >>> src/bram_ecc64.sv
// Purpose: 64-bit single-correct double-detect encoder and decoder
// Assumes: Encode and decode paths are independent
// Notes: Data sits at non power-of-two positions 3..71
`timescale 1ns/1ps
module bram_ecc64 (
   bram_ecc_if.unit e
);
   always_comb
   begin
      logic [6:0] chk;
      logic [6:0] syn;
      logic par;
      int k;
      chk = 7'h00;
      syn = 7'h00;
      par = 1'b0;
      k = 0;
      e.dec_fixed = e.dec_data;
      for (int q = 1; q < 72; q++)
      begin
         if ((q & (q - 1)) != 0)
         begin
            if (e.enc_data[k])
               chk = chk ^ 7'(q);
            if (e.dec_data[k])
               syn = syn ^ 7'(q);
            k = k + 1;
         end
      end
      e.enc_check = {(^e.enc_data) ^ (^chk), chk};
      syn = syn ^ e.dec_check[6:0];
      par = (^e.dec_data) ^ (^e.dec_check);
      k = 0;
      for (int q = 1; q < 72; q++)
      begin
         if ((q & (q - 1)) != 0)
         begin
            if (par && syn == 7'(q))
               e.dec_fixed[k] = ~e.dec_data[k];
            k = k + 1;
         end
      end
      e.sbit = par;
      e.dbit = !par && syn != 7'h00;
   end
endmodule : bram_ecc64

// >>> tb/dual_port_block_ram_sva.sv
// Purpose: Concurrent checks on the block memory top ports
// Assumes: Bound from the bench top file
// Notes: Hold checks skip cycles with output resets, cascade or APB writes
`timescale 1ns/1ps
module dual_port_block_ram_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] port_en,
   input wire logic [3:0] port_rst_latch,
   input wire logic [3:0] port_rst_reg,
   input wire logic [1:0] cas_sel,
   input wire logic [3:0][63:0] port_dout
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic bad_addr;
   logic [3:0] quiet;
   assign bad_addr = (paddr > 8'h20) || (paddr[1:0] != 2'h0);
   assign quiet = ~port_en & ~port_rst_latch & ~port_rst_reg & ~{2'h0, cas_sel}
      & {4{!(psel && pwrite)}};
   chk_ready_always: assert property (pready)
      else $error("pready low");
   chk_unmapped_err: assert property (psel && penable && bad_addr |-> pslverr)
      else $error("no error on unmapped address");
   chk_mapped_ok: assert property (psel && penable && !bad_addr |-> !pslverr)
      else $error("error on mapped address");
   chk_err_read_zero: assert property (psel && penable && !pwrite && bad_addr |-> prdata == 32'h0)
      else $error("unmapped read data not zero");
   chk_prdata_holds: assert property ($changed(prdata) |-> $past(psel && !penable))
      else $error("read data changed outside setup");
   chk_hold_port0: assert property (quiet[0] ##1 quiet[0] |-> $stable(port_dout[0]))
      else $error("port 0 output changed while idle");
   chk_hold_port1: assert property (quiet[1] ##1 quiet[1] |-> $stable(port_dout[1]))
      else $error("port 1 output changed while idle");
   chk_hold_port2: assert property (quiet[2] ##1 quiet[2] |-> $stable(port_dout[2]))
      else $error("port 2 output changed while idle");
   chk_hold_port3: assert property (quiet[3] ##1 quiet[3] |-> $stable(port_dout[3]))
      else $error("port 3 output changed while idle");
   cover property (psel && penable && bad_addr);
   cover property (port_en[1] ##2 port_en[1]);
   cover property (port_en[2]);
endmodule : dual_port_block_ram_sva

// >>> tb/port_user.sv
// Purpose: Fabric user logic driving the four memory ports
// Assumes: Calls start just after a rising pclk edge
// Notes: Data lines show inverted values between operations
`timescale 1ns/1ps
module port_user (
   input wire logic pclk,
   output logic [3:0] port_en,
   output logic [3:0][8:0] port_we,
   output logic [3:0][11:0] port_addr,
   output logic [3:0][63:0] port_din,
   output logic [3:0][7:0] port_dinp
);
   initial
   begin
      port_en = 4'h0;
      port_we = '0;
      port_addr = '0;
      port_din = '0;
      port_dinp = '0;
   end
   // One port per call, so two ports never write one place together
   task automatic op(input int p, input logic [8:0] we, input logic [11:0] a,
      input logic [71:0] d);
      port_en[p] <= 1'b1;
      port_we[p] <= we;
      port_addr[p] <= a;
      port_din[p] <= d[63:0];
      port_dinp[p] <= d[71:64];
      @(posedge pclk);
      port_en[p] <= 1'b0;
      port_we[p] <= 9'h000;
      port_din[p] <= ~d[63:0];
      port_dinp[p] <= ~d[71:64];
      @(posedge pclk);
   endtask : op
endmodule : port_user

// >>> tb/dual_port_block_ram_test.sv
// Purpose: Self-checking bench for the two-port block memory
// Assumes: Fabric user model drives the ports, bench drives APB
// Notes: Cascade and output set/reset inputs driven by the bench
`timescale 1ns/1ps
`include "bram_defines.svh"
module dual_port_block_ram_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] port_en;
   logic [3:0][8:0] port_we;
   logic [3:0][11:0] port_addr;
   logic [3:0][63:0] port_din;
   logic [3:0][7:0] port_dinp;
   logic [3:0][63:0] port_dout;
   logic [3:0][7:0] port_doutp;
   logic [3:0] port_rst_latch = 4'h0;
   logic [3:0] port_rst_reg = 4'h0;
   logic [1:0][71:0] cas_in = '0;
   logic [1:0] cas_sel = 2'h0;
   logic [1:0][71:0] cas_out;
   logic ecc_sbit;
   logic ecc_dbit;
   logic [31:0] rdv;
   logic errv;
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   dual_port_block_ram dual_port_block_ram_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .port_en, .port_we, .port_addr, .port_din,
      .port_dinp, .port_rst_latch, .port_rst_reg, .port_dout, .port_doutp, .cas_in, .cas_sel,
      .cas_out, .ecc_sbit, .ecc_dbit);
   port_user port_user_inst (.pclk, .port_en, .port_we, .port_addr, .port_din, .port_dinp);
   initial
   begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rdv === ex && errv === e, "register read");
   endtask : rdc
   task automatic rd2(input int p, input logic [11:0] a);
      port_user_inst.op(p, 9'h000, a, 72'h0);
      port_user_inst.op(p, 9'h000, a, 72'h0);
   endtask : rd2
   function automatic logic [8:0] lane0(input int p);
      return {port_doutp[p][0], port_dout[p][7:0]};
   endfunction : lane0
   task automatic t_regs;
      rdc(`OFF_PORTCFG, `PORTCFG_RST, 1'b0);
      rdc(8'h24, 32'h0, 1'b1);
      rdc(8'h02, 32'h0, 1'b1);
      apb(1'b1, 8'h24, 32'hffff_ffff);
      chk(errv === 1'b1, "unmapped write accepted");
      $display("t_regs done");
   endtask : t_regs
   task automatic t_basic;
      apb(1'b1, `OFF_CTRL, 32'h0000_0040);
      port_user_inst.op(0, 9'h1ff, 12'h008, 72'h01_0000_0000_0000_00a5);
      port_user_inst.op(1, 9'h000, 12'h008, 72'h0);
      chk(lane0(1) === 9'h000, "register stage early");
      port_user_inst.op(1, 9'h000, 12'h008, 72'h0);
      chk(lane0(1) === 9'h1a5, "read of other port write");
      port_user_inst.op(0, 9'h1ff, 12'h008, 72'h00_0000_0000_0000_005a);
      chk(lane0(1) === 9'h1a5, "output not held");
      $display("t_basic done");
   endtask : t_basic
   task automatic t_width;
      logic [8:0] ex [4];
      ex = '{9'h011, 9'h000, 9'h033, 9'h000};
      apb(1'b1, `OFF_PORTCFG, 32'h4040_4048);
      port_user_inst.op(0, 9'h005, 12'h010, 72'h05_0000_0000_4433_2211);
      for (int i = 0; i < 4; i++)
      begin
         rd2(1, 12'h010 + 12'(i));
         chk(lane0(1) === ex[i], "byte lane read");
      end
      $display("t_width done");
   endtask : t_width
   task automatic t_wmode;
      logic [8:0] old_v;
      logic [8:0] nv;
      logic [8:0] ex;
      old_v = 9'h000;
      for (int m = 0; m < 3; m++)
      begin
         nv = 9'h100 + 9'(m);
         ex = (m == 0) ? nv : (m == 1) ? old_v : 9'h05a;
         apb(1'b1, `OFF_PORTCFG, 32'h4040_4040 | (m << 12));
         rd2(1, 12'h008);
         port_user_inst.op(1, 9'h1ff, 12'h020, {7'h0, nv[8], 56'h0, nv[7:0]});
         port_user_inst.op(1, 9'h000, 12'h008, 72'h0);
         chk(lane0(1) === ex, "read during write");
         old_v = nv;
      end
      $display("t_wmode done");
   endtask : t_wmode
   task automatic t_split;
      apb(1'b1, `OFF_PORTCFG, `PORTCFG_RST);
      apb(1'b1, `OFF_CTRL, 32'h0000_0041);
      port_user_inst.op(2, 9'h1ff, 12'h004, 72'h00_0000_0000_0000_003c);
      rd2(3, 12'h004);
      chk(lane0(3) === 9'h03c, "high half read");
      rd2(0, 12'h004);
      chk(lane0(0) === 9'h05a, "low half read");
      apb(1'b1, `OFF_CTRL, 32'h0000_0040);
      rd2(1, 12'h00c);
      chk(lane0(1) === 9'h03c, "whole view of high half");
      $display("t_split done");
   endtask : t_split
   task automatic t_sdp;
      apb(1'b1, `OFF_CTRL, 32'h0000_0042);
      apb(1'b1, `OFF_PORTCFG, 32'h4040_4340);
      port_user_inst.op(0, 9'h1ff, 12'h018, 72'hff_8877_6655_4433_2211);
      rd2(1, 12'h018);
      chk({port_doutp[1], port_dout[1]} === 72'hff_8877_6655_4433_2211, "wide read");
      $display("t_sdp done");
   endtask : t_sdp
   task automatic t_rst;
      apb(1'b1, `OFF_CTRL, 32'h0000_0040);
      apb(1'b1, `OFF_SRVAL, 32'h0155_00aa);
      apb(1'b1, `OFF_PORTCFG, 32'h4040_00c0);
      port_rst_latch[1] <= 1'b1;
      port_user_inst.op(1, 9'h000, 12'h008, 72'h0);
      port_rst_latch[1] <= 1'b0;
      chk(lane0(1) === 9'h155, "sync latch reset");
      port_rst_reg[0] <= 1'b1;
      @(posedge pclk);
      chk(lane0(0) === 9'h0aa, "async reset override");
      port_rst_reg[0] <= 1'b0;
      apb(1'b1, `OFF_CTRL, 32'h0000_01c0);
      cas_in[0] <= {8{9'h0c3}};
      cas_sel[0] <= 1'b1;
      repeat (2) @(posedge pclk);
      cas_in[0] <= '0;
      @(negedge pclk);
      chk(port_dout[0] === 64'hc3c3_c3c3_c3c3_c3c3 && cas_out[0] === {8{9'h0c3}},
         "cascade pipe");
      @(posedge pclk);
      cas_sel[0] <= 1'b0;
      $display("t_rst done");
   endtask : t_rst
   task automatic t_ecc;
      apb(1'b1, `OFF_PORTCFG, 32'h4040_4340);
      apb(1'b1, `OFF_CTRL, 32'h0000_005e);
      port_user_inst.op(0, 9'h1ff, 12'h030, 72'h00_0123_4567_89ab_cdef);
      rd2(1, 12'h030);
      chk(port_dout[1] === 64'h0123_4567_89ab_cdef && ecc_sbit === 1'b1, "single fix");
      apb(1'b1, `OFF_CTRL, 32'h0000_006e);
      port_user_inst.op(0, 9'h1ff, 12'h038, 72'h00_0123_4567_89ab_cdef);
      rd2(1, 12'h038);
      chk(ecc_dbit === 1'b1 && ecc_sbit === 1'b0, "double detect");
      rdc(`OFF_STATUS, 32'h0000_0006, 1'b0);
      apb(1'b1, `OFF_STATUS, 32'h0000_0006);
      rdc(`OFF_STATUS, 32'h0000_0000, 1'b0);
      $display("t_ecc done");
   endtask : t_ecc
   task automatic t_init;
      apb(1'b1, `OFF_CTRL, 32'h0000_0000);
      apb(1'b1, `OFF_INIT_ROW, 32'h0000_0005);
      apb(1'b1, `OFF_INIT_D0, 32'h0000_01c3);
      apb(1'b1, `OFF_INIT_CMD, 32'h0000_0001);
      apb(1'b1, `OFF_CTRL, 32'h0000_0040);
      rd2(1, 12'h028);
      chk(lane0(1) === 9'h1c3, "row load");
      apb(1'b1, `OFF_CTRL, 32'h0000_0000);
      apb(1'b1, `OFF_INIT_CMD, 32'h0000_0002);
      rdc(`OFF_STATUS, 32'h0000_0001, 1'b0);
      repeat (520) @(posedge pclk);
      rdc(`OFF_STATUS, 32'h0000_0000, 1'b0);
      apb(1'b1, `OFF_CTRL, 32'h0000_0040);
      rd2(1, 12'h028);
      chk(lane0(1) === 9'h000, "clear all");
      $display("t_init done");
   endtask : t_init
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_basic();
      t_width();
      t_wmode();
      t_split();
      t_sdp();
      t_rst();
      t_ecc();
      t_init();
      give_verdict();
   end
endmodule : dual_port_block_ram_test
bind dual_port_block_ram dual_port_block_ram_sva dual_port_block_ram_sva_inst (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .port_en, .port_rst_latch,
   .port_rst_reg, .cas_sel, .port_dout);
